// ===== src/dat_map.svh
// register offsets, field positions, codes and reset values
`ifndef DAT_MAP_SVH
`define DAT_MAP_SVH

// ****************************************
// register offsets, byte addresses
// ****************************************
`define DAT_OFF_STATUS      8'h04
`define DAT_OFF_STATUS_CLR  8'h08
`define DAT_OFF_CHIP_ID     8'hf0
`define DAT_OFF_CHIP_ID_EXT 8'hf4
`define DAT_OFF_AP_ID       8'hfc

// ****************************************
// status fields
// ****************************************
`define DAT_ST_HCR_BIT      1
`define DAT_ST_PROT_BIT     9
`define DAT_ST_DBGP_BIT     10

// ****************************************
// instruction codes and widths
// ****************************************
`define DAT_IR_W            4
`define DAT_IR_IDCODE       4'h1
`define DAT_IR_AP_ACCESS    4'h8
`define DAT_IR_BYPASS       4'hf
`define DAT_IR_CAPTURE      4'h1
`define DAT_ADDR_W          8
`define DAT_WORD_W          32
`define DAT_ACC_W           41
`define DAT_ACC_WR_BIT      0
`define DAT_ACC_ADDR_LSB    1
`define DAT_ACC_ADDR_MSB    8
`define DAT_ACC_DATA_LSB    9
`define DAT_ACC_DATA_MSB    40
`define DAT_AP_RSVD         8'h00

`endif

// ===== src/dat_pkg.sv
// types shared by the debug and test access port
package dat_pkg;

  // ****************************************
  // tap controller states
  // ****************************************
  typedef enum logic [3:0] {
    DAT_TLR,
    DAT_RTI,
    DAT_SEL_DR,
    DAT_CAP_DR,
    DAT_SHIFT_DR,
    DAT_EXIT1_DR,
    DAT_PAUSE_DR,
    DAT_EXIT2_DR,
    DAT_UPD_DR,
    DAT_SEL_IR,
    DAT_CAP_IR,
    DAT_SHIFT_IR,
    DAT_EXIT1_IR,
    DAT_PAUSE_IR,
    DAT_EXIT2_IR,
    DAT_UPD_IR
  } dat_tap_state_e;

endpackage

// ===== src/dat_debug_access_test_port.sv
// debug pin enable, core hold reset, tap controller and port registers
//
// Notes on behaviour
// (RL1) jtag pins enable on a tck falling edge seen after reset release
// (RL2) tck low at reset release keeps the core held in reset
// (RL3) clearing the hold bit through status clear releases the core
// (RL4) five tck periods of tms high always reach test-logic-reset
// (RL5) debugger applies five tms-high periods before any command
// (RL6) tms low in test-logic-reset moves to run-test/idle
// (RL7) tck high at reset release leaves jtag pins disabled; here any later tck falling edge still enables them
// (RL8) tms 1,1,0,0 from idle reaches shift-ir
// (RL9) shift-ir moves a 4-bit instruction in from tdi
// (RL10) instruction selects data register between tdi and tdo
// (RL11) tms 1,1,0 returns to idle; instruction latched in update-ir
// (RL12) tms 1,0,0 from idle reaches shift-dr
// (RL13) shift-dr shifts tdi in and captured bits out on tdo
// (RL14) latched data register output changes only in update-dr
// (RL15) instruction scan may go straight to data scan
// (RL16) protected state blocks system bus access
// (RL17) protected state ignores hold-reset release from the port
// (RL18) protected state limits checksum to the whole flash
// (RL19) protected state still allows hot plug, user page, erase, id
// (RL20) port id word holds revision, codes, class, id and variant
// (RL21) class bit is one only for a memory access port
// (RL22) chip id and extension words mirrored read-only
// (RL23) protected state ignores writing one to hold clear bit
// (RL24) hold status bit reads one while core held in reset
// (RL25) full sixteen-state tap machine on rising tck
// (RL26) tdo changes on falling tck, driven only in shift states
`timescale 1ns/1ns
`include "dat_map.svh"

module dat_debug_access_test_port #(
  parameter logic [3:0]  AP_REVISION   = 4'h2, // arbitrary value
  parameter logic [3:0]  AP_CONT_CODE  = 4'h5, // arbitrary value
  parameter logic [6:0]  AP_IDENT_CODE = 7'h2a, // arbitrary value
  parameter logic        AP_IS_MEM_AP  = 1'b0,
  parameter logic [3:0]  AP_ID         = 4'h3, // arbitrary value
  parameter logic [3:0]  AP_ID_VARIANT = 4'h1, // arbitrary value
  parameter logic [31:0] JTAG_IDCODE   = 32'h0abc_d001 // arbitrary value
) (
  input  wire logic                    mclk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    tck_in,
  input  wire logic                    tms_in,
  input  wire logic                    tdi_in,
  output logic                         tdo_out,
  output logic                         tdo_oe_out,
  input  wire logic                    prot_state_in,
  input  wire logic [31:0]             chip_id_in,
  input  wire logic [31:0]             chip_id_ext_in,
  output logic                         core_hold_reset_out,
  output logic                         jtag_enabled_out,
  output logic                         sysbus_access_en_out,
  output logic                         crc_full_flash_only_out,
  output logic                         user_page_read_en_out,
  output logic                         chip_erase_en_out,
  output dat_pkg::dat_tap_state_e      tap_state_out
);
  import dat_pkg::*;

  // ****************************************
  // chip clock side: tck level and enable
  // ****************************************
  logic tck_s1_reg;
  logic tck_s2_reg;
  logic tck_s3_reg;
  logic decided_reg;
  logic decided_next;
  logic hold_reg;
  logic hold_next;
  logic jtag_en_reg;
  logic jtag_en_next;

  wire tck_fall = tck_s3_reg & ~tck_s2_reg;

  // pin level passes two flops before any logic reads it
  always_ff @(posedge mclk_in)
  begin
    tck_s1_reg <= tck_in;
    tck_s2_reg <= tck_s1_reg;
    tck_s3_reg <= tck_s2_reg;
  end

  // ****************************************
  // tck side signals needed below
  // ****************************************
  logic                   req_tgl_reg;
  logic                   acc_wr_reg;
  logic [`DAT_ADDR_W-1:0] acc_addr_reg;
  logic [`DAT_WORD_W-1:0] acc_wdata_reg;

  // ****************************************
  // request crossing into chip clock
  // ****************************************
  logic req_s1_reg;
  logic req_s2_reg;
  logic req_s3_reg;
  logic ack_tgl_reg;
  logic [`DAT_WORD_W-1:0] rdata_reg;
  logic [`DAT_WORD_W-1:0] rdata_next;

  always_ff @(posedge mclk_in)
  begin
    req_s1_reg <= req_tgl_reg;
    req_s2_reg <= req_s1_reg;
  end

  // bundled fields stay still while the toggle crosses
  wire req_pulse = req_s2_reg ^ req_s3_reg;
  wire hold_clr_req = req_pulse & acc_wr_reg
                    & (acc_addr_reg == `DAT_OFF_STATUS_CLR)
                    & acc_wdata_reg[`DAT_ST_HCR_BIT];
  wire hold_clr_ok = hold_clr_req & ~prot_state_in; // RL17 RL23

  // ****************************************
  // hold reset and pin enable decision
  // ****************************************
  // decision taken once, on the first edge after release
  always_comb
  begin
    decided_next = 1'b1;
    hold_next    = hold_reg;
    jtag_en_next = jtag_en_reg;
    if (!decided_reg)
      hold_next = ~tck_s2_reg; // RL2
    else if (hold_clr_ok)
      hold_next = 1'b0; // RL3
    if (decided_reg && tck_fall)
      jtag_en_next = 1'b1; // RL1 RL19
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      decided_reg <= 1'b0;
      hold_reg    <= 1'b1;
      jtag_en_reg <= 1'b0; // RL7
    end
    else
    begin
      decided_reg <= decided_next;
      hold_reg    <= hold_next;
      jtag_en_reg <= jtag_en_next;
    end
  end

  assign core_hold_reset_out = hold_reg;
  assign jtag_enabled_out    = jtag_en_reg;

  // ****************************************
  // protected state gating
  // ****************************************
  assign sysbus_access_en_out    = ~prot_state_in; // RL16
  assign crc_full_flash_only_out = prot_state_in; // RL18
  assign user_page_read_en_out   = 1'b1; // RL19
  assign chip_erase_en_out       = 1'b1; // RL19

  // ****************************************
  // port register read decode
  // ****************************************
  wire [7:0]  ap_id_rsvd = `DAT_AP_RSVD;
  wire [31:0] ap_id_word = {AP_REVISION, AP_CONT_CODE, AP_IDENT_CODE,
                            AP_IS_MEM_AP, ap_id_rsvd, AP_ID,
                            AP_ID_VARIANT}; // RL20 RL21

  logic [31:0] status_word;
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`DAT_ST_HCR_BIT]  = hold_reg; // RL24
    status_word[`DAT_ST_PROT_BIT] = prot_state_in;
    status_word[`DAT_ST_DBGP_BIT] = jtag_en_reg;
  end

  wire sel_status  = acc_addr_reg == `DAT_OFF_STATUS;
  wire sel_cid     = acc_addr_reg == `DAT_OFF_CHIP_ID;
  wire sel_cid_ext = acc_addr_reg == `DAT_OFF_CHIP_ID_EXT;
  wire sel_ap_id   = acc_addr_reg == `DAT_OFF_AP_ID;

  assign rdata_next = ({32{sel_status}}  & status_word)
                    | ({32{sel_cid}}     & chip_id_in) // RL22
                    | ({32{sel_cid_ext}} & chip_id_ext_in) // RL22
                    | ({32{sel_ap_id}}   & ap_id_word); // RL19

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      req_s3_reg  <= 1'b0;
      ack_tgl_reg <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      req_s3_reg <= req_s2_reg;
      if (req_pulse)
      begin
        ack_tgl_reg <= ~ack_tgl_reg;
        rdata_reg   <= rdata_next;
      end
    end
  end

  // ****************************************
  // tck side: enable and ack crossing
  // ****************************************
  logic en_t1_reg;
  logic en_t2_reg;
  logic ack_t1_reg;
  logic ack_t2_reg;

  always_ff @(posedge tck_in)
  begin
    en_t1_reg  <= jtag_en_reg;
    en_t2_reg  <= en_t1_reg;
    ack_t1_reg <= ack_tgl_reg;
    ack_t2_reg <= ack_t1_reg;
  end

  // ****************************************
  // tap state machine
  // ****************************************
  dat_tap_state_e state_reg;
  dat_tap_state_e state_next;

  always_comb
  begin
    case (state_reg) // RL25
      DAT_TLR:      state_next = tms_in ? DAT_TLR      : DAT_RTI; // RL6
      DAT_RTI:      state_next = tms_in ? DAT_SEL_DR   : DAT_RTI;
      DAT_SEL_DR:   state_next = tms_in ? DAT_SEL_IR   : DAT_CAP_DR; // RL12
      DAT_CAP_DR:   state_next = tms_in ? DAT_EXIT1_DR : DAT_SHIFT_DR;
      DAT_SHIFT_DR: state_next = tms_in ? DAT_EXIT1_DR : DAT_SHIFT_DR;
      DAT_EXIT1_DR: state_next = tms_in ? DAT_UPD_DR   : DAT_PAUSE_DR;
      DAT_PAUSE_DR: state_next = tms_in ? DAT_EXIT2_DR : DAT_PAUSE_DR;
      DAT_EXIT2_DR: state_next = tms_in ? DAT_UPD_DR   : DAT_SHIFT_DR;
      DAT_UPD_DR:   state_next = tms_in ? DAT_SEL_DR   : DAT_RTI;
      DAT_SEL_IR:   state_next = tms_in ? DAT_TLR      : DAT_CAP_IR; // RL4
      DAT_CAP_IR:   state_next = tms_in ? DAT_EXIT1_IR : DAT_SHIFT_IR; // RL8
      DAT_SHIFT_IR: state_next = tms_in ? DAT_EXIT1_IR : DAT_SHIFT_IR;
      DAT_EXIT1_IR: state_next = tms_in ? DAT_UPD_IR   : DAT_PAUSE_IR;
      DAT_PAUSE_IR: state_next = tms_in ? DAT_EXIT2_IR : DAT_PAUSE_IR;
      DAT_EXIT2_IR: state_next = tms_in ? DAT_UPD_IR   : DAT_SHIFT_IR;
      DAT_UPD_IR:   state_next = tms_in ? DAT_SEL_DR   : DAT_RTI; // RL11 RL15
      default:      state_next = DAT_TLR;
    endcase
  end

  // disabled pins hold the tap in test-logic-reset
  always_ff @(posedge tck_in)
  begin
    if (!en_t2_reg)
      state_reg <= DAT_TLR;
    else
      state_reg <= state_next;
  end

  assign tap_state_out = state_reg;

  // ****************************************
  // instruction register
  // ****************************************
  logic [`DAT_IR_W-1:0] ir_sr_reg;
  logic [`DAT_IR_W-1:0] ir_reg;

  always_ff @(posedge tck_in)
  begin
    if (!en_t2_reg || state_reg == DAT_TLR)
    begin
      ir_sr_reg <= `DAT_IR_CAPTURE;
      ir_reg    <= `DAT_IR_IDCODE;
    end
    else
    begin
      if (state_reg == DAT_CAP_IR)
        ir_sr_reg <= `DAT_IR_CAPTURE;
      else if (state_reg == DAT_SHIFT_IR)
        ir_sr_reg <= {tdi_in, ir_sr_reg[`DAT_IR_W-1:1]}; // RL9
      if (state_reg == DAT_UPD_IR)
        ir_reg <= ir_sr_reg; // RL11
    end
  end

  // ****************************************
  // data registers
  // ****************************************
  wire sel_idcode = ir_reg == `DAT_IR_IDCODE; // RL10
  wire sel_access = ir_reg == `DAT_IR_AP_ACCESS; // RL10

  logic [`DAT_ACC_W-1:0] dr_sr_reg;
  logic [`DAT_ACC_W-1:0] dr_sr_next;
  wire                   acc_done = ack_t2_reg == req_tgl_reg;

  // capture words of the data registers
  localparam int PAD_W = `DAT_ACC_W - `DAT_WORD_W;
  wire [PAD_W-1:0]      idcode_pad  = {PAD_W{1'b0}};
  wire [`DAT_ACC_W-1:0] acc_capture = {rdata_reg, acc_addr_reg, acc_done};
  wire [`DAT_ACC_W-1:0] id_capture  = {idcode_pad, JTAG_IDCODE};

  always_comb
  begin
    dr_sr_next = dr_sr_reg;
    if (state_reg == DAT_CAP_DR)
    begin
      if (sel_access)
        dr_sr_next = acc_capture;
      else if (sel_idcode)
        dr_sr_next = id_capture;
      else
        dr_sr_next = {`DAT_ACC_W{1'b0}};
    end
    else if (state_reg == DAT_SHIFT_DR) // RL13
    begin
      dr_sr_next = {1'b0, dr_sr_reg[`DAT_ACC_W-1:1]};
      if (sel_access)
        dr_sr_next[`DAT_ACC_W-1] = tdi_in;
      else if (sel_idcode)
        dr_sr_next[`DAT_WORD_W-1] = tdi_in;
      else
        dr_sr_next[0] = tdi_in;
    end
  end

  // access request latched only in update-dr
  wire acc_update = state_reg == DAT_UPD_DR & sel_access; // RL14

  always_ff @(posedge tck_in)
  begin
    if (!en_t2_reg)
    begin
      dr_sr_reg     <= {`DAT_ACC_W{1'b0}};
      req_tgl_reg   <= ack_t2_reg;
      acc_wr_reg    <= 1'b0;
      acc_addr_reg  <= `DAT_OFF_AP_ID;
      acc_wdata_reg <= 32'h0000_0000;
    end
    else
    begin
      dr_sr_reg <= dr_sr_next;
      if (acc_update && acc_done)
      begin
        req_tgl_reg   <= ~req_tgl_reg;
        acc_wr_reg    <= dr_sr_reg[`DAT_ACC_WR_BIT];
        acc_addr_reg  <= dr_sr_reg[`DAT_ACC_ADDR_MSB:`DAT_ACC_ADDR_LSB];
        acc_wdata_reg <= dr_sr_reg[`DAT_ACC_DATA_MSB:`DAT_ACC_DATA_LSB];
      end
    end
  end

  // ****************************************
  // tdo on falling tck
  // ****************************************
  logic tdo_reg;
  logic tdo_oe_reg;

  wire in_shift_ir = state_reg == DAT_SHIFT_IR;
  wire in_shift_dr = state_reg == DAT_SHIFT_DR;
  wire shift_any   = in_shift_ir | in_shift_dr;
  wire tdo_next    = in_shift_ir ? ir_sr_reg[0] : dr_sr_reg[0];

  always_ff @(negedge tck_in)
  begin
    tdo_oe_reg <= shift_any; // RL26
    tdo_reg    <= tdo_next; // RL26
  end

  // disabled pins never drive, whatever the tap holds
  assign tdo_oe_out = tdo_oe_reg & jtag_en_reg;
  assign tdo_out    = tdo_reg & tdo_oe_out;

endmodule

// ===== dv/dat_props.sv
// assertions on the debug and test access port pins
`timescale 1ns/1ns

module dat_props
  import dat_pkg::*;
(
  input wire logic           mclk_in,
  input wire logic           nrst_in,
  input wire logic           tck_in,
  input wire logic           tms_in,
  input wire logic           tdo_oe_out,
  input wire logic           prot_state_in,
  input wire logic           core_hold_reset_out,
  input wire logic           jtag_enabled_out,
  input wire logic           sysbus_access_en_out,
  input wire logic           crc_full_flash_only_out,
  input dat_pkg::dat_tap_state_e tap_state_out
);
  // ****************************************
  // chip clock side
  // ****************************************
  property p_bus;
    @(posedge mclk_in) disable iff (!nrst_in)
      sysbus_access_en_out == !prot_state_in;
  endproperty
  a_bus: assert property (p_bus) else $error("bus gate wrong");
  property p_crc;
    @(posedge mclk_in) disable iff (!nrst_in)
      crc_full_flash_only_out == prot_state_in;
  endproperty
  a_crc: assert property (p_crc) else $error("crc limit wrong");
  property p_hold;
    @(posedge mclk_in) disable iff (!nrst_in)
      $past(nrst_in, 2) && $fell(core_hold_reset_out)
      |-> !$past(prot_state_in);
  endproperty
  a_hold: assert property (p_hold) else $error("hold freed");
  // ****************************************
  // test clock side
  // ****************************************
  property p_oe;
    @(posedge tck_in) disable iff (!nrst_in)
      tdo_oe_out |-> tap_state_out inside {DAT_SHIFT_IR, DAT_SHIFT_DR};
  endproperty
  a_oe: assert property (p_oe) else $error("tdo driven");
  property p_tlr;
    @(posedge tck_in) disable iff (!jtag_enabled_out)
      tms_in [*5] |=> tap_state_out == DAT_TLR;
  endproperty
  a_tlr: assert property (p_tlr) else $error("no reset state");
  property p_rti;
    @(posedge tck_in) disable iff (!jtag_enabled_out)
      tap_state_out == DAT_TLR && !tms_in |=> tap_state_out == DAT_RTI;
  endproperty
  a_rti: assert property (p_rti) else $error("no idle");
  property p_sir;
    @(posedge tck_in) disable iff (!jtag_enabled_out)
      tap_state_out == DAT_RTI && tms_in ##1 tms_in ##1 !tms_in
      ##1 !tms_in |=> tap_state_out == DAT_SHIFT_IR;
  endproperty
  a_sir: assert property (p_sir) else $error("no shift ir");
  property p_sdr;
    @(posedge tck_in) disable iff (!jtag_enabled_out)
      tap_state_out == DAT_RTI && tms_in ##1 !tms_in ##1 !tms_in
      |=> tap_state_out == DAT_SHIFT_DR;
  endproperty
  a_sdr: assert property (p_sdr) else $error("no shift dr");
endmodule

// ===== dv/dat_jtag_host.sv
// debugger model driving the test access pins
`timescale 1ns/1ns

module dat_jtag_host (
  output logic     tck_out,
  output logic     tms_out,
  output logic     tdi_out,
  input wire logic tdo_in
);
  bit at_sel;
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
    at_sel = 1'b0;
  end
  // one tck period, tdo taken before the rise
  task automatic clk(input logic m, input logic d, output logic o);
    tms_out = m;
    tdi_out = d;
    #24;
    o = tdo_in;
    tck_out = 1'b1;
    #24;
    tck_out = 1'b0;
  endtask
  task automatic lvl(input logic v);
    tck_out = v;
  endtask
  task automatic idle(input int n);
    logic o;
    repeat (n) clk(1'b0, 1'b0, o);
  endtask
  task automatic tap_reset();
    logic o;
    repeat (8) clk(1'b1, 1'b0, o);
    clk(1'b0, 1'b0, o);
    at_sel = 1'b0;
  endtask
  // scan from idle, or from select-dr after a chained scan
  task automatic scan(input bit ir, input int n, input logic [40:0] di,
                      input logic nx, output logic [40:0] dq);
    logic o;
    dq = '0;
    if (!at_sel) clk(1'b1, 1'b0, o);
    if (ir) clk(1'b1, 1'b0, o);
    clk(1'b0, 1'b0, o);
    clk(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      clk(i == n - 1, di[i], o);
      dq[i] = o;
    end
    clk(1'b1, 1'b0, o);
    clk(nx, 1'b0, o);
    at_sel = nx;
  endtask
endmodule

// ===== dv/dat_tb.sv
// testbench for the debug and test access port
`timescale 1ns/1ns

module testbench;
  import dat_pkg::*;
  logic           mclk_in;
  logic           nrst_in;
  logic           prot;
  wire            tck;
  wire            tms;
  wire            tdi;
  wire            tdo_w;
  logic           tdo, oe, hold, jen, bus, crc, upr, cer, b;
  dat_tap_state_e st;
  logic [31:0]    cid, cidx, q;
  logic [40:0]    c;
  int             err_count, check_count;

  dat_debug_access_test_port dut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(oe), .prot_state_in(prot),
    .chip_id_in(cid), .chip_id_ext_in(cidx), .core_hold_reset_out(hold),
    .jtag_enabled_out(jen), .sysbus_access_en_out(bus),
    .crc_full_flash_only_out(crc), .user_page_read_en_out(upr),
    .chip_erase_en_out(cer), .tap_state_out(st));
  // released tdo line shows a changing pattern
  assign tdo_w = oe ? tdo : mclk_in;
  dat_jtag_host host (
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_w));

  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [40:0] g, e, input string m);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic mck(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic ap(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    host.scan(1'b0, 41, {d, a, w}, 1'b0, c);
    host.idle(6);
    host.scan(1'b0, 41, {d, a, w}, 1'b0, c);
    host.idle(6);
    chk(c[8:0], {a, 1'b1}, "access done");
    r = c[40:9];
  endtask
  initial
  begin
    #200000;
    err_count++;
    print_verdict();
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    err_count = 0;
    check_count = 0;
    nrst_in = 1'b0;
    prot = 1'b0;
    cid = 32'h1234_5678;
    cidx = 32'h9abc_def0;
    mck(12);
    nrst_in = 1'b1;
    mck(4);
    chk(hold, 1'b1, "hold at release");
    chk(jen, 1'b0, "pins early");
    host.clk(1'b1, 1'b0, b);
    mck(4);
    chk(jen, 1'b1, "pins enabled");
    $display("test boot done");
    host.tap_reset();
    chk(st, DAT_RTI, "idle state");
    host.scan(1'b0, 32, '0, 1'b0, c);
    chk(c[31:0], 32'h0abc_d001, "idcode");
    host.scan(1'b1, 4, 41'hf, 1'b0, c);
    chk(c[3:0], 4'h1, "ir capture");
    host.scan(1'b0, 2, 41'h3, 1'b0, c);
    chk(c[1:0], 2'b10, "bypass");
    host.scan(1'b1, 4, 41'h8, 1'b1, c);
    $display("test tap done");
    ap(1'b0, 8'hfc, 32'h0, q);
    chk(q, {8'h25, 7'h2a, 1'b0, 8'h00, 8'h31}, "port id");
    ap(1'b1, 8'hf0, 32'h0, q);
    ap(1'b0, 8'hf0, 32'h0, q);
    chk(q, cid, "chip id");
    ap(1'b0, 8'hf4, 32'h0, q);
    chk(q, cidx, "chip id ext");
    ap(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    ap(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h402, "status held");
    $display("test regs done");
    prot = 1'b1;
    mck(2);
    chk({bus, crc, upr, cer}, 4'h7, "protected gates");
    ap(1'b1, 8'h08, 32'h2, q);
    ap(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h602, "hold kept");
    mck(1);
    prot = 1'b0;
    mck(2);
    chk({bus, crc}, 2'b10, "open gates");
    ap(1'b1, 8'h08, 32'h2, q);
    chk(hold, 1'b0, "hold freed");
    ap(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h400, "status free");
    $display("test prot done");
    host.clk(1'b1, 1'b0, b);
    host.clk(1'b1, 1'b0, b);
    host.clk(1'b0, 1'b0, b);
    host.clk(1'b0, 1'b0, b);
    mck(1);
    chk({st, oe}, {DAT_SHIFT_IR, 1'b1}, "shift ir drive");
    host.tap_reset();
    mck(1);
    chk({st, oe}, {DAT_RTI, 1'b0}, "reset from shift");
    host.scan(1'b0, 32, '0, 1'b0, c);
    chk(c[31:0], 32'h0abc_d001, "idcode after reset");
    $display("test reset done");
    mck(1);
    nrst_in = 1'b0;
    host.lvl(1'b1);
    mck(12);
    nrst_in = 1'b1;
    mck(4);
    chk({jen, hold}, 2'b00, "pins off");
    $display("test disable done");
    print_verdict();
  end
endmodule

bind dat_debug_access_test_port dat_props u_props (
  .mclk_in, .nrst_in, .tck_in, .tms_in, .tdo_oe_out, .prot_state_in,
  .core_hold_reset_out, .jtag_enabled_out, .sysbus_access_en_out,
  .crc_full_flash_only_out, .tap_state_out);
